// File: src/aca_top.sv
// Contract
// - writing one to control bit 7 starts the self-calibration sequence.
// - bit 7 reads one while calibration runs and clears itself when it ends.
// - calibration fails, setting bit 6, on hardware trigger select, a register write or stop.
// - starting calibration aborts any conversion in progress at once.
// - writing one to the failed flag clears it; writing zero leaves it.
// - the failed flag reads zero after a good calibration and one after a failed one.
// - with bit 3 clear one trigger gives one conversion or set; with it set they repeat.
// - bit 2 turns hardware averaging on, so each result comes from a set of conversions.
// - the two-bit count field selects 4, 8, 16 or 32 samples per set.
// - bits 31 to 8 and 5 to 4 of the control register read as zero.
// - trigger select low uses the software trigger, high the hardware trigger.
// - conversion active rises on a start and falls on completion or abort.
`timescale 1ns/1ps
`include "aca_map.svh"
module aca_top #(
    parameter int ADDR_W     = 8,
    parameter int CAL_CYCLES = `ACA_CAL_CYCLES
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output aca_pkg::aca_resp_t     s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output aca_pkg::aca_resp_t     s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              trigger_select_hardware,
    input  wire logic              sw_trigger,
    input  wire logic              hw_trigger,
    input  wire logic              conv_done,
    input  wire logic              other_reg_write,
    input  wire logic              stop_mode,
    output logic                   conv_start,
    output logic                   conv_abort,
    output logic                   conversion_active,
    output logic                   set_done,
    output logic                   calibration_running,
    output logic                   irq
);
    import aca_pkg::*;

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic logic [4:0] avg_last(input logic [1:0] sel);
        logic [5:0] n;
        n = 6'h04 << sel;
        return 5'(n - 6'h01);
    endfunction

    function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        return a == ADDR_W'(off);
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    aca_state_e        st;
    aca_state_e        next_st;
    logic              calibration_failed_flag;
    logic              cont_en;
    logic              avg_en;
    logic [1:0]        avg_sel;
    logic [4:0]        sample_cnt;
    logic [2:0]        events;
    logic [2:0]        ev_mask;
    logic              cal_done_ok;
    logic              wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0]       wr_data;
    logic [3:0]        wr_strb;
    logic [31:0]       rd_data;

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    wire wr_ctrl = wr_en & addr_is(wr_addr, `ACA_OFF_CTRL);
    wire wr_ctrl_lo = wr_ctrl & wr_strb[0];
    wire wr_stat_lo = wr_en & wr_strb[0] & addr_is(wr_addr, `ACA_OFF_STATUS);
    wire wr_mask_lo = wr_en & wr_strb[0] & addr_is(wr_addr, `ACA_OFF_MASK);
    wire wr_err = ~(addr_is(wr_addr, `ACA_OFF_CTRL) | addr_is(wr_addr, `ACA_OFF_STATUS)
                  | addr_is(wr_addr, `ACA_OFF_MASK));
    wire rd_ctrl = addr_is(s_axi_araddr, `ACA_OFF_CTRL);
    wire rd_stat = addr_is(s_axi_araddr, `ACA_OFF_STATUS);
    wire rd_mask = addr_is(s_axi_araddr, `ACA_OFF_MASK);
    wire rd_err = ~(rd_ctrl | rd_stat | rd_mask);

    // reserved control bits are never stored, so they read back as zero
    wire [31:0] ctrl_view = {24'h00_0000, calibration_running, calibration_failed_flag, 2'h0,
                             cont_en, avg_en, avg_sel};

    assign rd_data = rd_ctrl ? ctrl_view
                   : rd_stat ? {29'h0, events}
                   : rd_mask ? {29'h0, ev_mask}
                   : 32'h0000_0000;

    aca_axil_slave #(
        .ADDR_W (ADDR_W)
    ) u_bus (
        .clk           (clk),
        .rst           (rst),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .wr_err        (wr_err),
        .rd_data       (rd_data),
        .rd_err        (rd_err)
    );

    // ----------------------------------------------------------------
    // calibration
    // ----------------------------------------------------------------
    wire cal_req = wr_ctrl_lo & wr_data[`ACA_BIT_CAL] & ~calibration_running;
    // any write to the control register during calibration counts as a disturbance
    wire cal_fail = calibration_running
                  & (trigger_select_hardware | stop_mode | wr_ctrl | other_reg_write);
    wire calibration_failed_flag_w1c = wr_ctrl_lo & wr_data[`ACA_BIT_CALIBRATION_FAILED_FLAG];

    aca_cal_seq #(
        .CAL_CYCLES (CAL_CYCLES)
    ) u_cal (
        .clk     (clk),
        .rst     (rst),
        .start   (cal_req),
        .fail    (cal_fail),
        .running (calibration_running),
        .done_ok (cal_done_ok)
    );

    // a new calibration clears the old outcome; a failure wins over a clear
    wire next_calibration_failed_flag = cal_fail ? 1'b1 : (cal_req | calibration_failed_flag_w1c) ? 1'b0 : calibration_failed_flag;

    // ----------------------------------------------------------------
    // conversion sequencing
    // ----------------------------------------------------------------
    wire trig = trigger_select_hardware ? hw_trigger : sw_trigger;
    wire last_sample = ~avg_en | (sample_cnt == avg_last(avg_sel));
    wire in_conv = (st == ACA_ST_CONV);
    wire sample_in = in_conv & conv_done & ~cal_req;
    wire set_end = sample_in & last_sample;
    wire first_start = (st == ACA_ST_IDLE) & trig & ~cal_req & ~calibration_running;
    // continuous mode chains sets; clearing it lets the current set finish
    wire next_start = first_start | (sample_in & (~last_sample | cont_en));

    always_comb begin
        next_st = st;
        case (st)
            ACA_ST_IDLE: begin
                if (cal_req) begin
                    next_st = ACA_ST_CAL;
                end else if (first_start) begin
                    next_st = ACA_ST_CONV;
                end
            end
            ACA_ST_CONV: begin
                if (cal_req) begin
                    next_st = ACA_ST_CAL;
                end else if (set_end & ~cont_en) begin
                    next_st = ACA_ST_IDLE;
                end
            end
            ACA_ST_CAL: begin
                if (~calibration_running & ~cal_req) begin
                    next_st = ACA_ST_IDLE;
                end
            end
            default: next_st = ACA_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st                <= ACA_ST_IDLE;
            sample_cnt        <= 5'h00;
            conv_start        <= 1'b0;
            conv_abort        <= 1'b0;
            set_done          <= 1'b0;
            conversion_active <= 1'b0;
        end else begin
            st                <= next_st;
            conv_start        <= next_start;
            conv_abort        <= cal_req & in_conv;
            set_done          <= set_end;
            conversion_active <= (next_st == ACA_ST_CONV);
            if (first_start | set_end | cal_req) begin
                sample_cnt <= 5'h00;
            end else if (sample_in) begin
                sample_cnt <= sample_cnt + 5'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // control register and events
    // ----------------------------------------------------------------
    wire [2:0] ev_in = {set_end, cal_fail, cal_done_ok};
    wire [2:0] ev_clr = wr_stat_lo ? wr_data[2:0] : 3'h0;
    wire [2:0] next_events = (events & ~ev_clr) | ev_in;

    always_ff @(posedge clk) begin
        if (rst) begin
            {calibration_failed_flag, cont_en, avg_en, avg_sel} <= 5'h00;
            events  <= `ACA_RST_EVENTS;
            ev_mask <= `ACA_RST_EVENTS;
            irq     <= 1'b0;
        end else begin
            calibration_failed_flag   <= next_calibration_failed_flag;
            events <= next_events;
            irq    <= |(next_events & (wr_mask_lo ? wr_data[2:0] : ev_mask));
            if (wr_ctrl_lo) begin
                cont_en <= wr_data[`ACA_BIT_CONT];
                avg_en  <= wr_data[`ACA_BIT_AVERAGE_ENABLE];
                avg_sel <= wr_data[`ACA_AVERAGE_COUNT_SELECT_HI:`ACA_AVERAGE_COUNT_SELECT_LO];
            end
            if (wr_mask_lo) begin
                ev_mask <= wr_data[2:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_cal_start;
        @(posedge clk) disable iff (rst)
        cal_req |=> calibration_running && ctrl_view[7];
    endproperty
    a_cal_start: assert property (p_cal_start) else $error("calibration did not start");

    property p_cal_self_clear;
        @(posedge clk) disable iff (rst)
        cal_done_ok |-> !calibration_running && $past(calibration_running);
    endproperty
    a_cal_self_clear: assert property (p_cal_self_clear) else $error("cal bit not cleared");

    property p_cal_fail_stop;
        @(posedge clk) disable iff (rst)
        calibration_running && stop_mode |=> calibration_failed_flag && !calibration_running;
    endproperty
    a_cal_fail_stop: assert property (p_cal_fail_stop) else $error("stop did not fail cal");

    property p_cal_abort;
        @(posedge clk) disable iff (rst)
        cal_req && in_conv |=> conv_abort && !conversion_active;
    endproperty
    a_cal_abort: assert property (p_cal_abort) else $error("conversion not aborted");

    property p_calibration_failed_flag_clear;
        @(posedge clk) disable iff (rst)
        calibration_failed_flag && calibration_failed_flag_w1c && !cal_fail |=> !calibration_failed_flag;
    endproperty
    a_calibration_failed_flag_clear: assert property (p_calibration_failed_flag_clear) else $error("failed flag not cleared");

    property p_calibration_failed_flag_good;
        @(posedge clk) disable iff (rst)
        cal_done_ok |-> !calibration_failed_flag;
    endproperty
    a_calibration_failed_flag_good: assert property (p_calibration_failed_flag_good) else $error("flag set after good cal");

    property p_single;
        @(posedge clk) disable iff (rst)
        set_end && !cont_en && !cal_req |=> !conversion_active && !conv_start;
    endproperty
    a_single: assert property (p_single) else $error("single mode kept converting");

    property p_avg_count;
        @(posedge clk) disable iff (rst)
        sample_in && avg_en && sample_cnt == avg_last(avg_sel) |=> set_done;
    endproperty
    a_avg_count: assert property (p_avg_count) else $error("set length wrong");

    property p_sw_trig;
        @(posedge clk) disable iff (rst)
        st == ACA_ST_IDLE && !trigger_select_hardware && sw_trigger && !cal_req
            && !calibration_running |=> conv_start && conversion_active;
    endproperty
    a_sw_trig: assert property (p_sw_trig) else $error("software trigger ignored");

    property p_continuous;
        @(posedge clk) disable iff (rst)
        set_end && cont_en |=> conv_start && set_done && conversion_active;
    endproperty
    a_continuous: assert property (p_continuous) else $error("no restart");

endmodule

// File: src/aca_map.svh
`ifndef ACA_MAP_SVH
`define ACA_MAP_SVH

// --------------------------------------------------------------------
// register offsets (byte addresses)
// --------------------------------------------------------------------
`define ACA_OFF_CTRL      8'h24
`define ACA_OFF_STATUS    8'h40
`define ACA_OFF_MASK      8'h44

// --------------------------------------------------------------------
// control register fields
// --------------------------------------------------------------------
`define ACA_BIT_CAL       7
`define ACA_BIT_CALIBRATION_FAILED_FLAG      6
`define ACA_BIT_CONT      3
`define ACA_BIT_AVERAGE_ENABLE      2
`define ACA_AVERAGE_COUNT_SELECT_HI       1
`define ACA_AVERAGE_COUNT_SELECT_LO       0

// --------------------------------------------------------------------
// status / mask fields
// --------------------------------------------------------------------
`define ACA_EV_CAL_OK     0
`define ACA_EV_CAL_FAIL   1
`define ACA_EV_SET_DONE   2

// --------------------------------------------------------------------
// reset values and timing
// --------------------------------------------------------------------
`define ACA_RST_CTRL      8'h00
`define ACA_RST_EVENTS    3'h0
`define ACA_CAL_CYCLES    1024

`endif

// File: src/aca_pkg.sv
package aca_pkg;

    typedef enum logic [2:0] {
        ACA_ST_IDLE = 3'b001,
        ACA_ST_CONV = 3'b010,
        ACA_ST_CAL  = 3'b100
    } aca_state_e;

    typedef logic [1:0] aca_resp_t;

    localparam aca_resp_t ACA_RESP_OKAY   = 2'h0;
    localparam aca_resp_t ACA_RESP_SLVERR = 2'h2;

endpackage

// File: src/aca_axil_slave.sv
`timescale 1ns/1ps
module aca_axil_slave #(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output aca_pkg::aca_resp_t     s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output aca_pkg::aca_resp_t     s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic                   wr_en,
    output logic [ADDR_W-1:0]      wr_addr,
    output logic [31:0]            wr_data,
    output logic [3:0]             wr_strb,
    input  wire logic              wr_err,
    input  wire logic [31:0]       rd_data,
    input  wire logic              rd_err
);
    import aca_pkg::*;

    logic aw_held;
    logic w_held;

    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take  = s_axi_wvalid & s_axi_wready;
    wire b_done  = s_axi_bvalid & s_axi_bready;
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire r_done  = s_axi_rvalid & s_axi_rready;

    // the register write happens in the first cycle where both halves are held
    assign wr_en = aw_held & w_held & ~s_axi_bvalid;

    always_ff @(posedge clk) begin
        if (rst) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= ACA_RESP_OKAY;
            wr_addr       <= '0;
            wr_data       <= 32'h0000_0000;
            wr_strb       <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_held       <= 1'b1;
                s_axi_awready <= 1'b0;
                wr_addr       <= s_axi_awaddr;
            end
            if (w_take) begin
                w_held       <= 1'b1;
                s_axi_wready <= 1'b0;
                wr_data      <= s_axi_wdata;
                wr_strb      <= s_axi_wstrb;
            end
            if (wr_en) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_err ? ACA_RESP_SLVERR : ACA_RESP_OKAY;
            end
            if (b_done) begin
                s_axi_bvalid  <= 1'b0;
                aw_held       <= 1'b0;
                w_held        <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= ACA_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_data;
            s_axi_rresp   <= rd_err ? ACA_RESP_SLVERR : ACA_RESP_OKAY;
        end else if (r_done) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

endmodule

// File: src/aca_cal_seq.sv
`timescale 1ns/1ps
module aca_cal_seq #(
    parameter int CAL_CYCLES = 1024
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic start,
    input  wire logic fail,
    output logic      running,
    output logic      done_ok
);
    localparam int CW = $clog2(CAL_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CAL_CYCLES - 1);

    logic [CW-1:0] cnt;

    wire finish = running & ~fail & (cnt == LAST);

    // a failure ends the sequence at once; results would be invalid anyway
    always_ff @(posedge clk) begin
        if (rst) begin
            running <= 1'b0;
            done_ok <= 1'b0;
            cnt     <= '0;
        end else begin
            done_ok <= finish;
            if (start & ~running) begin
                running <= 1'b1;
                cnt     <= '0;
            end else if (finish | (running & fail)) begin
                running <= 1'b0;
            end else if (running) begin
                cnt <= cnt + CW'(1);
            end
        end
    end

endmodule

// File: dv/tb_top.sv
`timescale 1ns/1ps
`include "aca_map.svh"
module tb_top;
    import aca_pkg::*;
    localparam int CALC  = 16;
    localparam int LIMIT = 20000;
    logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    aca_resp_t   bresp, rresp, r;
    logic        trigger_select_hardware, sw_trigger, hw_trigger, conv_done;
    logic        other_reg_write, stop_mode, conv_start, conv_abort;
    logic        conversion_active, set_done, calibration_running, irq;
    int          err_count, total_checks, n_start, n_done, n_abort, cyc, dly, b, nd, i;

    aca_top #(.ADDR_W(8), .CAL_CYCLES(CALC)) dut (
        .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .trigger_select_hardware(trigger_select_hardware), .sw_trigger(sw_trigger),
        .hw_trigger(hw_trigger), .conv_done(conv_done), .other_reg_write(other_reg_write),
        .stop_mode(stop_mode), .conv_start(conv_start), .conv_abort(conv_abort),
        .conversion_active(conversion_active), .set_done(set_done),
        .calibration_running(calibration_running), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // --------------------------------------------------------------------
    // converter stand-in: answers each start four cycles later
    // --------------------------------------------------------------------
    always @(posedge clk) begin
        conv_done <= 1'b0;
        if (rst || conv_abort) dly <= 0;
        else if (conv_start) dly <= 3;
        else if (dly != 0) begin
            dly <= dly - 1;
            if (dly == 1) conv_done <= 1'b1;
        end
        if (conv_start) n_start <= n_start + 1;
        if (set_done) n_done <= n_done + 1;
        if (conv_abort) n_abort <= n_abort + 1;
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            err_count++;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    // waits on the response for as long as it takes; only the global cycle limit ends a hang
    task automatic axw(input logic [7:0] a, input logic [31:0] v, output aca_resp_t rs);
        @(posedge clk);
        awaddr <= a; wdata <= v; wstrb <= 4'hF;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] v, output aca_resp_t rs);
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    task automatic trig(input bit hw);
        @(posedge clk);
        if (hw) hw_trigger <= 1'b1;
        else sw_trigger <= 1'b1;
        @(posedge clk);
        hw_trigger <= 1'b0;
        sw_trigger <= 1'b0;
    endtask

    task automatic wait_done(input int n);
        int t;
        t = 0;
        while (n_done < n && t < 3000) begin
            @(posedge clk);
            t++;
        end
        repeat (8) @(posedge clk);
    endtask

    task automatic final_report;
        $display("mismatches %0d comparisons %0d", err_count, total_checks);
        if (err_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // --------------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------------
    initial begin
        rst = 1'b1; awaddr = '0; araddr = '0; wdata = '0; wstrb = '0;
        awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
        trigger_select_hardware = 0; sw_trigger = 0; hw_trigger = 0;
        other_reg_write = 0; stop_mode = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        axr(`ACA_OFF_CTRL, d, r); chk(d, 32'h0);
        axr(8'h10, d, r); chk(r, ACA_RESP_SLVERR);
        chk(d, 32'h0);
        axw(8'h10, 32'h1, r); chk(r, ACA_RESP_SLVERR);
        axw(`ACA_OFF_CTRL, 32'hFFFF_FF3F, r);
        axr(`ACA_OFF_CTRL, d, r); chk(d, 32'h0F);
        for (i = 0; i < 4; i++) begin
            axw(`ACA_OFF_CTRL, 32'h4 | i, r);
            b = n_start; nd = n_done;
            trig(0);
            wait_done(nd + 1);
            chk(n_start - b, 4 << i);
            chk(conversion_active, 1'b0);
        end
        // hardware select must ignore the software trigger
        axw(`ACA_OFF_CTRL, 32'h0, r);
        trigger_select_hardware <= 1'b1;
        b = n_start; nd = n_done;
        trig(0);
        repeat (8) @(posedge clk);
        chk(n_start - b, 0);
        trig(1);
        wait_done(nd + 1);
        chk(n_start - b, 1);
        trigger_select_hardware <= 1'b0;
        axw(`ACA_OFF_CTRL, 32'h8, r);
        nd = n_done;
        trig(0);
        wait_done(nd + 3);
        chk(conversion_active, 1'b1);
        b = n_abort;
        axw(`ACA_OFF_CTRL, 32'h88, r);
        // the abort counter updates on the edge that ends the write; let it settle
        @(posedge clk);
        chk(n_abort - b, 1);
        chk(conversion_active, 1'b0);
        chk(calibration_running, 1'b1);
        axr(`ACA_OFF_CTRL, d, r); chk(d, 32'h88);
        repeat (CALC + 4) @(posedge clk);
        axr(`ACA_OFF_CTRL, d, r); chk(d, 32'h08);
        axr(`ACA_OFF_STATUS, d, r); chk(d, 32'h5);
        // each failure cause in turn; a control write is the last one
        for (i = 0; i < 4; i++) begin
            axw(`ACA_OFF_CTRL, 32'h80, r);
            @(posedge clk);
            case (i)
                0: other_reg_write <= 1'b1;
                1: stop_mode <= 1'b1;
                2: trigger_select_hardware <= 1'b1;
                default: axw(`ACA_OFF_CTRL, 32'h0, r);
            endcase
            @(posedge clk);
            other_reg_write <= 1'b0; stop_mode <= 1'b0; trigger_select_hardware <= 1'b0;
            repeat (3) @(posedge clk);
            chk(calibration_running, 1'b0);
            axr(`ACA_OFF_CTRL, d, r); chk(d, 32'h40);
        end
        axw(`ACA_OFF_CTRL, 32'h0, r);
        axr(`ACA_OFF_CTRL, d, r); chk(d, 32'h40);
        axw(`ACA_OFF_CTRL, 32'h40, r);
        axr(`ACA_OFF_CTRL, d, r); chk(d, 32'h0);
        // interrupt: raise masked, unmask, clear
        axw(`ACA_OFF_STATUS, 32'h7, r);
        axr(`ACA_OFF_STATUS, d, r); chk(d, 32'h0);
        axw(`ACA_OFF_CTRL, 32'h80, r);
        axw(`ACA_OFF_CTRL, 32'h0, r);
        axr(`ACA_OFF_STATUS, d, r); chk(d, 32'h2);
        chk(irq, 1'b0);
        axw(`ACA_OFF_MASK, 32'h2, r);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1);
        axw(`ACA_OFF_STATUS, 32'h2, r);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        final_report();
    end
endmodule
